// File: asp_defines.svh
// constants of the converter serial result port
`ifndef ASP_DEFINES_SVH
`define ASP_DEFINES_SVH

// ****************************************
// clock and timing
// ****************************************
`define ASP_CLK_KHZ 25000
`define ASP_CONV60_MS 133
`define ASP_CONV50_MS 160
`define ASP_CONV_CLKS 20480
`define ASP_ISCK_DIV 8

// ****************************************
// frame and reset values
// ****************************************
`define ASP_FRAME_BITS 32
`define ASP_BIT_LAST 6'h1f
`define ASP_MODE_RST 1'b1
`define ASP_EOC_BUSY 1'b1
`define ASP_EOC_READY 1'b0

`endif

// File: asp_pkg.sv
// types of the converter serial result port
package asp_pkg;

    // ****************************************
    // port state machine
    // ****************************************
    typedef enum logic [2:0] {
        ASP_CONV = 3'b001,
        ASP_SLEEP = 3'b010,
        ASP_SHIFT = 3'b100
    } asp_state_t;

endpackage : asp_pkg

// File: asp_edge.sv
// edge finder for a pin sampled on the system clock
`timescale 1ns/1ps
module asp_edge (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic ce,
    input wire logic rst_val,
    input wire logic din,
    output logic prev,
    output logic rise,
    output logic fall
);

    logic prev_q;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            prev_q <= rst_val;
        end else if (ce) begin
            prev_q <= din;
        end
    end

    assign prev = prev_q;
    // edges only count while the block is enabled
    assign rise = ce & din & ~prev_q;
    assign fall = ce & ~din & prev_q;

endmodule : asp_edge

// File: asp_tick.sv
// half-period tick for the internally made serial clock
`timescale 1ns/1ps
module asp_tick #(
    parameter int HALF = 648
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic ce,
    input wire logic run,
    output logic tick
);

    logic [15:0] cnt_q;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            cnt_q <= 16'h0000;
        end else if (ce) begin
            if (!run || tick) begin
                cnt_q <= 16'h0000;
            end else begin
                cnt_q <= cnt_q + 16'h0001;
            end
        end
    end

    assign tick = ce & run & (cnt_q == 16'(HALF - 1));

endmodule : asp_tick

// File: asp_result_port.sv
// serial result port of a delta-sigma converter
//
// Functional notes
// RL1 - each next data bit appears on the data pin at a serial clock fall
// RL2 - internal serial clock is the conversion clock divided by eight, driven out; the code derives it from CONV60_CYC for both rejection frequencies
// RL3 - clock source picked at power-up and each chip select fall; low means external
// RL4 - data pin driver off whenever chip select is high
// RL5 - chip select low while converting or asleep shows busy flag: high busy, low ready
// RL6 - finished conversion always enters sleep, whatever chip select does
// RL7 - sleep holds the result until a clock rise with chip select low starts output
// RL8 - chip select rise during output aborts it and starts a new conversion
// RL9 - frame is 32 bits; flag at first rise, last result bit at 32nd rise
// RL10 - external clock: 32nd fall starts conversion and drives the data pin high
// RL11 - host may cut the frame short by raising chip select
// RL12 - host samples data on clock rises since the port changes it on falls
// RL13 - chip select held low gives continuous conversion at the selected rate
// RL14 - host holds clock low before power-up ends to choose external clock
// RL15 - in two-wire use the result loads as the busy flag falls
// RL16 - two-wire: sleep until first rise, 32nd fall starts the next conversion
// RL17 - host may watch the falling busy flag as a ready interrupt
// RL18 - conversion time is a cycle counter; the core supplies the frame at the end
`timescale 1ns/1ps
`include "asp_defines.svh"
module asp_result_port #(
    parameter int CNT_W = 23,
    parameter int CONV60_CYC = `ASP_CONV60_MS * `ASP_CLK_KHZ,
    parameter int CONV50_CYC = `ASP_CONV50_MS * `ASP_CLK_KHZ,
    parameter int ISCK_HALF = (CONV60_CYC / `ASP_CONV_CLKS) * `ASP_ISCK_DIV / 2
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic ce,
    input wire logic cs_n,
    input wire logic sck_in,
    output logic sck_out,
    output logic sck_oe,
    output logic sdo_out,
    output logic sdo_oe,
    input wire logic rejection_freq_select,
    input wire logic [31:0] frame_data,
    output logic conv_start,
    output logic conv_done,
    output logic int_sck_mode
);

    // ****************************************
    // state
    // ****************************************
    asp_pkg::asp_state_t state_q;
    logic [CNT_W-1:0] cnt_q;
    logic [31:0] shift_q;
    logic [5:0] bits_q;
    logic int_mode_q;
    logic por_q;
    logic isck_q;
    logic armed_q;
    logic conv_start_q;
    logic conv_done_q;
    logic sdo_q;

    logic cs_prev;
    logic cs_rise;
    logic cs_fall;
    logic sck_prev;
    logic ext_rise;
    logic ext_fall;
    logic run;
    logic tick;
    logic i_rise;
    logic i_fall;
    logic sck_r;
    logic sck_f;
    logic restart;
    logic frame_end;

    // ****************************************
    // helpers
    // ****************************************
    // conversion length for the selected rejection frequency
    function automatic logic [CNT_W-1:0] conv_len(input logic sel);
        logic [CNT_W-1:0] len;
        len = sel ? CNT_W'(CONV50_CYC - 1) : CNT_W'(CONV60_CYC - 1);
        return len;
    endfunction : conv_len

    // last counted cycle of a conversion: result load and done strobe
    function automatic logic conv_last(input asp_pkg::asp_state_t st,
        input logic [CNT_W-1:0] cnt);
        logic last;
        last = (st == asp_pkg::ASP_CONV) && (cnt == '0);
        return last;
    endfunction : conv_last

    // states in which the serial clock is listened to
    function automatic logic link_on(input asp_pkg::asp_state_t st);
        logic on;
        on = (st == asp_pkg::ASP_SLEEP) || (st == asp_pkg::ASP_SHIFT);
        return on;
    endfunction : link_on

    // ****************************************
    // pin edges
    // ****************************************
    asp_edge u_cs_edge (
        .clk(clk),
        .sys_rst(sys_rst),
        .ce(ce),
        .rst_val(1'b1),
        .din(cs_n),
        .prev(cs_prev),
        .rise(cs_rise),
        .fall(cs_fall)
    );

    asp_edge u_sck_edge (
        .clk(clk),
        .sys_rst(sys_rst),
        .ce(ce),
        .rst_val(1'b1),
        .din(sck_in),
        .prev(sck_prev),
        .rise(ext_rise),
        .fall(ext_fall)
    );

    // ****************************************
    // clock source selection
    // ****************************************
    // the mode is caught on the first enabled cycle after reset, never under reset
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            por_q <= 1'b0;
            int_mode_q <= `ASP_MODE_RST;
        end else if (ce) begin
            if (!por_q) begin
                por_q <= 1'b1;
                int_mode_q <= sck_in; // RL3
            end else if (cs_fall) begin
                // sampled level from before our own driver could turn on
                int_mode_q <= sck_prev; // RL3
            end
        end
    end

    // ****************************************
    // internal serial clock
    // ****************************************
    assign run = int_mode_q & ~cs_n & link_on(state_q);

    asp_tick #(
        .HALF(ISCK_HALF)
    ) u_tick (
        .clk(clk),
        .sys_rst(sys_rst),
        .ce(ce),
        .run(run & armed_q),
        .tick(tick)
    );

    // clock idles high; pulled low on entering the ready check
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            isck_q <= 1'b1;
            armed_q <= 1'b0;
        end else if (ce) begin
            if (!run) begin
                isck_q <= 1'b1;
                armed_q <= 1'b0;
            end else if (!armed_q) begin
                isck_q <= 1'b0;
                armed_q <= 1'b1;
            end else if (tick) begin
                isck_q <= ~isck_q; // RL2
            end
        end
    end

    assign i_rise = run & armed_q & tick & ~isck_q;
    assign i_fall = run & armed_q & tick & isck_q;

    // ****************************************
    // unified clock events
    // ****************************************
    // outside chip select low the external clock is ignored
    assign sck_r = int_mode_q ? i_rise : (ext_rise & ~cs_n);
    assign sck_f = int_mode_q ? i_fall : (ext_fall & ~cs_n);

    // internal mode ends on the 32nd rise, external on the 32nd fall
    assign frame_end = (bits_q == `ASP_BIT_LAST)
        & (int_mode_q ? sck_r : sck_f); // RL9 RL10 RL16

    assign restart = (state_q == asp_pkg::ASP_SHIFT)
        & (cs_rise | frame_end); // RL8

    // ****************************************
    // conversion and output sequence
    // ****************************************
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state_q <= asp_pkg::ASP_CONV;
            cnt_q <= CNT_W'(CONV60_CYC - 1);
            bits_q <= 6'h00;
        end else if (ce) begin
            case (state_q)
                asp_pkg::ASP_CONV: begin
                    if (cnt_q == '0) begin
                        state_q <= asp_pkg::ASP_SLEEP; // RL6
                    end else begin
                        cnt_q <= cnt_q - CNT_W'(1); // RL18
                    end
                end
                asp_pkg::ASP_SLEEP: begin
                    if (sck_r) begin
                        state_q <= asp_pkg::ASP_SHIFT; // RL7
                        bits_q <= 6'h00;
                    end
                end
                asp_pkg::ASP_SHIFT: begin
                    if (restart) begin
                        // frame end or chip select rise; back to back frames while chip select stays low
                        state_q <= asp_pkg::ASP_CONV; // RL13
                        cnt_q <= conv_len(rejection_freq_select);
                    end else if (sck_f) begin
                        bits_q <= bits_q + 6'h01;
                    end
                end
                default: begin
                    state_q <= asp_pkg::ASP_CONV;
                    cnt_q <= conv_len(rejection_freq_select);
                end
            endcase
        end
    end

    // ****************************************
    // result shift register
    // ****************************************
    // static while asleep, so output may wait forever
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            shift_q <= 32'h0000_0000;
        end else if (ce) begin
            if (conv_last(state_q, cnt_q)) begin
                shift_q <= frame_data; // RL15 RL18
            end else if (state_q == asp_pkg::ASP_SHIFT && sck_f && !restart) begin
                shift_q <= {shift_q[30:0], 1'b0}; // RL1
            end
        end
    end

    // ****************************************
    // core strobes
    // ****************************************
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            conv_start_q <= 1'b0;
            conv_done_q <= 1'b0;
        end else if (ce) begin
            conv_start_q <= restart;
            conv_done_q <= conv_last(state_q, cnt_q);
        end else begin
            conv_start_q <= 1'b0;
            conv_done_q <= 1'b0;
        end
    end

    // ****************************************
    // pins
    // ****************************************
    // the clock pin is only driven while selected and chip select is low
    assign sck_out = isck_q; // RL2
    assign sck_oe = int_mode_q & ~cs_n;

    assign sdo_oe = ~cs_n; // RL4
    // registered so the pin never glitches as state and shift word change together
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            sdo_q <= `ASP_EOC_BUSY;
        end else if (ce) begin
            if (restart) begin
                // a cut frame loses the rest of its result
                sdo_q <= `ASP_EOC_BUSY; // RL8 RL10 RL16
            end else if (conv_last(state_q, cnt_q)) begin
                sdo_q <= `ASP_EOC_READY; // RL5 RL6
            end else if (!link_on(state_q)) begin
                sdo_q <= `ASP_EOC_BUSY; // RL5
            end else if (state_q == asp_pkg::ASP_SLEEP && sck_r) begin
                // bit 31 is expected to carry the ready flag
                sdo_q <= shift_q[31]; // RL7 RL9
            end else if (state_q == asp_pkg::ASP_SHIFT && sck_f) begin
                sdo_q <= shift_q[30]; // RL1
            end
        end
    end

    assign sdo_out = sdo_q;

    assign conv_start = conv_start_q;
    assign conv_done = conv_done_q;
    assign int_sck_mode = int_mode_q;

endmodule : asp_result_port

// File: asp_result_port_sva.sv
// assertion checker for the serial result port
`timescale 1ns/1ps
module asp_result_port_chk #(
    parameter int CNT_W = 23,
    parameter int CONV60_CYC = 3325000,
    parameter int CONV50_CYC = 4000000,
    parameter int ISCK_HALF = 648
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic ce,
    input wire logic cs_n,
    input wire logic sck_in,
    input wire logic sck_out,
    input wire logic sck_oe,
    input wire logic sdo_out,
    input wire logic sdo_oe,
    input wire logic rejection_freq_select,
    input wire logic [31:0] frame_data,
    input wire logic conv_start,
    input wire logic conv_done,
    input wire logic int_sck_mode
);
    int cyc_q;
    // saturates so a long sleep cannot wrap it
    always_ff @(posedge clk) begin
        if (sys_rst || conv_start) begin
            cyc_q <= 0;
        end else if (cyc_q < CONV50_CYC + 8) begin
            cyc_q <= cyc_q + 1;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    a_sdo_hiz: assert property (sdo_oe == !cs_n)
        else $error("data enable wrong");
    a_sck_drive: assert property (sck_oe |-> !cs_n && int_sck_mode)
        else $error("clock driven wrongly");
    a_sck_idle: assert property (ce && !sck_oe |=> sck_out)
        else $error("clock not idle high");
    a_start_busy: assert property (conv_start |-> sdo_out)
        else $error("no busy at start");
    a_done_ready: assert property (conv_done |-> !sdo_out)
        else $error("no ready at end");
    a_start_single: assert property (conv_start |=> !conv_start && !conv_done)
        else $error("pulse too long");
    a_conv_len: assert property (conv_done
        |-> cyc_q >= CONV60_CYC - 2 && cyc_q <= CONV50_CYC + 2)
        else $error("conversion length wrong");
    a_rise_fall: assert property ($rose(sdo_out) && !cs_n && !int_sck_mode
        |-> $past(!sck_in))
        else $error("data rose without clock fall");
    a_mode_take: assert property ($fell(cs_n) && $stable(sck_in)
        |-> ##2 (int_sck_mode == $past(sck_in, 2)))
        else $error("mode not taken");
endmodule : asp_result_port_chk

bind asp_result_port asp_result_port_chk #(.CNT_W(CNT_W), .CONV60_CYC(CONV60_CYC),
    .CONV50_CYC(CONV50_CYC), .ISCK_HALF(ISCK_HALF)) u_asp_result_port_chk (
    .clk(clk), .sys_rst(sys_rst), .ce(ce), .cs_n(cs_n), .sck_in(sck_in), .sck_out(sck_out),
    .sck_oe(sck_oe), .sdo_out(sdo_out), .sdo_oe(sdo_oe),
    .rejection_freq_select(rejection_freq_select), .frame_data(frame_data),
    .conv_start(conv_start), .conv_done(conv_done), .int_sck_mode(int_sck_mode));

// File: asp_host.sv
// host model driving an external serial clock
`timescale 1ns/1ps
module asp_host (
    input wire logic clk,
    input wire logic sdo_out,
    input wire logic sdo_oe,
    output logic sck
);
    logic last_q;
    logic sdo_line;
    // a released data pin reads as the inverse of its last level
    always_ff @(posedge clk) begin
        if (sdo_oe) begin
            last_q <= sdo_out;
        end
    end
    assign sdo_line = sdo_oe ? sdo_out : ~last_q;
    initial sck = 1'b0;
    // no wait after the last fall, so the caller can catch the restart
    task automatic xfer(input int bits, output logic [31:0] rx);
        rx = 32'h0;
        for (int i = 0; i < bits; i++) begin
            sck = 1'b1;
            rx = {rx[30:0], sdo_line};
            repeat (3) @(posedge clk);
            #1 sck = 1'b0;
            if (i < bits - 1) begin
                repeat (3) @(posedge clk);
                #1;
            end
        end
    endtask : xfer
endmodule : asp_host

// File: adc_serial_result_port_test.sv
// self-checking bench for the serial result port
`timescale 1ns/1ps
module adc_serial_result_port_test;
    localparam int C60 = 200;
    localparam int C50 = 240;
    localparam int HALF = 4;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic cs_n = 1'b1;
    logic sck_en = 1'b1;
    logic rfs = 1'b0;
    logic [31:0] frame = 32'h2a3c_96e1;
    logic sck_host, sck_pin, sck_out, sck_oe, sdo_out, sdo_oe;
    logic conv_start, conv_done, int_mode;
    logic [31:0] rx;
    int n_fail = 0;
    int n_checks = 0;
    int n;
    always #20 clk = ~clk;
    // weak pull-up when nobody drives the clock pin
    assign sck_pin = sck_oe ? sck_out : (sck_en ? sck_host : 1'b1);
    asp_result_port #(.CONV60_CYC(C60), .CONV50_CYC(C50), .ISCK_HALF(HALF)) u_asp_result_port (
        .clk(clk), .sys_rst(sys_rst), .ce(1'b1), .cs_n(cs_n), .sck_in(sck_pin),
        .sck_out(sck_out), .sck_oe(sck_oe), .sdo_out(sdo_out), .sdo_oe(sdo_oe),
        .rejection_freq_select(rfs), .frame_data(frame), .conv_start(conv_start),
        .conv_done(conv_done), .int_sck_mode(int_mode));
    asp_host u_asp_host (.clk(clk), .sdo_out(sdo_out), .sdo_oe(sdo_oe), .sck(sck_host));
    task automatic tick(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask : tick
    task automatic chk(input logic ok, input string what);
        n_checks++;
        if (ok !== 1'b1) begin
            n_fail++;
            $display("Error at %0t: %s", $time, what);
        end
    endtask : chk
    task automatic wait_pulse(input bit sel);
        n = 0;
        while ((sel ? conv_done : conv_start) !== 1'b1 && n < 400) begin
            tick(1);
            n++;
        end
        chk(n < 400, "pulse missing");
    endtask : wait_pulse
    task automatic close_out;
        $display("checks %0d fails %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : close_out
    task automatic t_mode;
        chk(int_mode === 1'b0, "mode");
        chk(sdo_oe === 1'b0, "pin driven");
        cs_n = 1'b0;
        tick(2);
        chk(sdo_oe === 1'b1 && sdo_out === 1'b1, "busy");
        wait_pulse(1'b1);
        chk(sdo_out === 1'b0, "ready");
        frame = 32'h4c71_0f5a;
        $display("t_mode done");
    endtask : t_mode
    task automatic t_frame;
        rfs = 1'b1;
        tick(4);
        chk(sdo_out === 1'b0, "left sleep");
        u_asp_host.xfer(32, rx);
        wait_pulse(1'b0);
        chk(n < 4, "late restart");
        chk(rx === 32'h2a3c_96e1, "frame");
        chk(sdo_out === 1'b1, "no busy");
        wait_pulse(1'b1);
        chk(n >= C50 - 2 && n <= C50 + 2, "slow length");
        rfs = 1'b0;
        $display("t_frame done");
    endtask : t_frame
    task automatic t_abort;
        u_asp_host.xfer(5, rx);
        cs_n = 1'b1;
        wait_pulse(1'b0);
        chk(n < 4, "no abort");
        chk(rx[4:0] === 5'h09 && sdo_oe === 1'b0, "short frame");
        wait_pulse(1'b1);
        chk(n >= C60 - 2 && n <= C60 + 2, "fast length");
        $display("t_abort done");
    endtask : t_abort
    task automatic t_internal;
        sck_en = 1'b0;
        tick(3);
        cs_n = 1'b0;
        n = 0;
        while (sck_out !== 1'b0 && n < 20) begin
            tick(1);
            n++;
        end
        n = 0;
        while (sck_out !== 1'b1 && n < 20) begin
            tick(1);
            n++;
        end
        chk(n >= HALF - 1 && n <= HALF + 1, "clock rate");
        chk(int_mode === 1'b1 && sck_oe === 1'b1, "internal clock");
        wait_pulse(1'b0);
        chk(sdo_out === 1'b1, "no busy");
        $display("t_internal done");
    endtask : t_internal
    initial begin
        tick(2);
        sys_rst = 1'b0;
        tick(2);
        t_mode();
        t_frame();
        t_abort();
        t_internal();
        close_out();
    end
    initial begin
        #(40 * 5000);
        n_fail++;
        close_out();
    end
endmodule : adc_serial_result_port_test
